// [inc/hsts_cfg.svh]
`ifndef HSTS_CFG_SVH
`define HSTS_CFG_SVH
// register offset and field positions
`define HSTS_OFFSET 8'h24
`define HSTS_BIT_XFER_DONE 0
`define HSTS_BIT_XFER_ERR 1
`define HSTS_BIT_PORT_CHG 2
`define HSTS_BIT_FL_WRAP 3
`define HSTS_BIT_SYS_ERR 4
`define HSTS_BIT_ADV 5
`define HSTS_BIT_HALTED 12
`define HSTS_BIT_RECLAIM 13
`define HSTS_BIT_PER_STATE 14
`define HSTS_BIT_ASYNC_STATE 15
`define HSTS_EVENT_MASK 6'h3f
`define HSTS_RESET_VALUE 32'h0000_1000
// cycles counted down after run/stop clear before halted can set while the pipeline drains
`define HSTS_DRAIN_CYCLES 4
`endif

// [inc/hsts_pkg.sv]
package hsts_pkg;
  typedef enum logic [1:0]
  {
    RUNNING,
    DRAINING,
    HALTED
  } run_state_t;
  typedef logic [5:0] event_vec_t;
endpackage : hsts_pkg

// [src/host_status_register.sv]
// Function
// [R01] software writes zero into reserved bits 31..16 and 11..6
// [R02] bit 15 shows real asynchronous schedule state, may lag enable
// [R03] bit 14 shows real periodic schedule state, may lag enable
// [R04] reclamation bit 13 resets zero, flags empty asynchronous schedule
// [R05] halted bit 12 resets one, reads zero while run/stop is one
// [R06] halted sets only after execution really stopped following clear
// [R07] bit 5 sets on next async advance after doorbell written
// [R08] bit 4 sets on parity error, master abort or target abort
// [R09] host system error clears run/stop to stop descriptor execution
// [R10] bit 3 sets on frame index wrap, bit 13 or 12 toggle
// [R11] bit 2 sets on owned port change or force resume rise
// [R12] port change flag loaded with OR of port changes on D3-to-D0
// [R13] bit 1 sets when completing a transaction yields an error
// [R14] error with interrupt-on-complete sets both error and complete
// [R15] bit 0 sets when descriptor with interrupt-on-complete retires
// [R16] bit 0 also sets on short packet detection
// [R17] writing one clears an event flag, zero leaves it
// [R18] interrupt raised when flag and its enable are both set
// [R19] 256-entry list sets wrap flag on index bit 11 toggle
// [R20] reserved bits read zero, writes to read-only bits ignored
`timescale 1ns/100ps
`default_nettype none
`include "hsts_cfg.svh"
module host_status_register
  import hsts_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access from the function's memory space decoder
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // command register and interrupt enables
  input wire logic run_stop_bit,
  input wire logic [5:0] irq_enable,
  input wire logic [13:0] frame_index,
  input wire logic [1:0] frame_list_size,
  // schedule engine state
  input wire logic async_running,
  input wire logic periodic_running,
  input wire logic async_empty,
  input wire logic pipeline_idle,
  input wire logic async_advanced,
  input wire logic doorbell_set,
  // transfer events
  input wire logic td_retired,
  input wire logic td_ioc,
  input wire logic td_error,
  input wire logic short_packet,
  input wire logic pci_parity_err,
  input wire logic master_abort,
  input wire logic target_abort,
  // ports
  input wire logic [NUM_PORTS-1:0] port_change_rise,
  input wire logic [NUM_PORTS-1:0] port_handoff,
  input wire logic [NUM_PORTS-1:0] force_resume_rise,
  input wire logic [NUM_PORTS-1:0] port_change_any,
  input wire logic d3_to_d0,
  // results
  output logic run_stop_clear,
  output logic irq,
  output logic async_sched_state,
  output logic periodic_sched_state,
  output logic halted_flag
);
  event_vec_t events_reg;
  event_vec_t set_vec;
  event_vec_t clr_vec;
  run_state_t run_reg;
  logic [2:0] drain_cnt_reg;
  logic reclamation_flag;
  logic doorbell_pend_reg;
  logic wrap_pulse;
  logic sel;
  logic port_evt;

  // frame list wrap detector
  wrap_detect u_wrap
  (
    .mclk(mclk),
    .rst(rst),
    .frame_index(frame_index),
    .frame_list_size(frame_list_size),
    .wrap_pulse(wrap_pulse)
  );

  assign sel = (reg_addr == `HSTS_OFFSET);
  // port changes count only on owned ports; a handed-off port belongs to the companion
  assign port_evt = |((port_change_rise & ~port_handoff) | force_resume_rise);

  // sources of each sticky event
  always_comb
  begin
    set_vec = '0;
    // an errored descriptor that asked for completion also flags done
    set_vec[`HSTS_BIT_XFER_DONE] = (td_retired && td_ioc)
      || (td_error && td_ioc) || short_packet; // [R15] [R16] [R14]
    set_vec[`HSTS_BIT_XFER_ERR] = td_error; // [R13]
    set_vec[`HSTS_BIT_PORT_CHG] = port_evt
      || (d3_to_d0 && |port_change_any); // [R11] [R12]
    set_vec[`HSTS_BIT_FL_WRAP] = wrap_pulse; // [R10]
    set_vec[`HSTS_BIT_SYS_ERR] = pci_parity_err || master_abort
      || target_abort; // [R08]
    set_vec[`HSTS_BIT_ADV] = doorbell_pend_reg && async_advanced; // [R07]
  end

  // write-one-to-clear; reserved and read-only bits ignore writes [R20]
  assign clr_vec = (reg_wr && sel) ? reg_wdata[5:0] : 6'h00; // [R17]

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge mclk)
  begin
    if (rst)
      events_reg <= 6'h00;
    else
      events_reg <= (events_reg & ~clr_vec) | set_vec; // [R17]
  end

  // doorbell armed until the next asynchronous advance
  always_ff @(posedge mclk)
  begin
    if (rst)
      doorbell_pend_reg <= 1'b0;
    else if (doorbell_set)
      doorbell_pend_reg <= 1'b1;
    else if (async_advanced)
      doorbell_pend_reg <= 1'b0; // [R07]
  end

  // run state: halted only once pipeline drained after run/stop clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      run_reg <= HALTED;
      drain_cnt_reg <= 3'h0;
    end
    else
    begin
      case (run_reg)
        RUNNING:
          if (!run_stop_bit)
          begin
            run_reg <= DRAINING;
            drain_cnt_reg <= 3'(`HSTS_DRAIN_CYCLES);
          end
        DRAINING:
          if (run_stop_bit)
            run_reg <= RUNNING;
          else if (drain_cnt_reg != 3'h0)
            drain_cnt_reg <= drain_cnt_reg - 3'h1;
          else if (pipeline_idle)
            run_reg <= HALTED; // [R06]
        HALTED:
          if (run_stop_bit)
            run_reg <= RUNNING;
        default:
          run_reg <= HALTED;
      endcase
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      halted_flag <= 1'b1; // [R05]
      reclamation_flag <= 1'b0; // [R04]
      async_sched_state <= 1'b0;
      periodic_sched_state <= 1'b0;
      run_stop_clear <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // halted drops with run/stop; set after the drain completes
      halted_flag <= !run_stop_bit && (run_reg == HALTED
        || (run_reg == DRAINING && drain_cnt_reg == 3'h0
        && pipeline_idle)); // [R05] [R06]
      reclamation_flag <= async_empty; // [R04]
      async_sched_state <= async_running; // [R02]
      periodic_sched_state <= periodic_running; // [R03]
      run_stop_clear <= set_vec[`HSTS_BIT_SYS_ERR]; // [R09]
      irq <= |(((events_reg & ~clr_vec) | set_vec) & irq_enable); // [R18]
    end
  end

  // read data; reserved bits read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd && sel)
    begin
      reg_rdata <= 32'h0000_0000; // [R20]
      reg_rdata[5:0] <= events_reg;
      reg_rdata[`HSTS_BIT_HALTED] <= halted_flag;
      reg_rdata[`HSTS_BIT_RECLAIM] <= reclamation_flag;
      reg_rdata[`HSTS_BIT_PER_STATE] <= periodic_sched_state;
      reg_rdata[`HSTS_BIT_ASYNC_STATE] <= async_sched_state;
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // checks
  AST_HALT_LOW_WHEN_RUN: assert property (@(posedge mclk) disable iff (rst)
    run_stop_bit |=> !halted_flag) else $error("halted while running"); // [R05]
  AST_SYSERR_STOPS: assert property (@(posedge mclk) disable iff (rst)
    (pci_parity_err || master_abort || target_abort) |=> run_stop_clear)
    else $error("system error did not stop"); // [R09]
  AST_SYSERR_FLAG: assert property (@(posedge mclk) disable iff (rst)
    master_abort |=> events_reg[4]) else $error("abort not flagged"); // [R08]
  AST_ERR_IOC_BOTH: assert property (@(posedge mclk) disable iff (rst)
    (td_error && td_ioc) |=> events_reg[1] && events_reg[0])
    else $error("error with ioc not both"); // [R14]
  AST_SHORT_PKT: assert property (@(posedge mclk) disable iff (rst)
    short_packet |=> events_reg[0]) else $error("short packet lost"); // [R16]
  AST_W1C_KEEP: assert property (@(posedge mclk) disable iff (rst)
    (events_reg[3] && !(reg_wr && sel && reg_wdata[3])) |=> events_reg[3])
    else $error("flag lost without clear"); // [R17]
  AST_WRAP_SET: assert property (@(posedge mclk) disable iff (rst)
    wrap_pulse |=> events_reg[3]) else $error("wrap lost"); // [R10]
  AST_NO_HALT_EARLY: assert property (@(posedge mclk) disable iff (rst)
    $fell(run_stop_bit) |=> !halted_flag [*2])
    else $error("halted before drain"); // [R06]
  AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
    (|(events_reg & irq_enable) && !(reg_wr && sel)) |=> irq)
    else $error("irq missing"); // [R18]
  AST_ASYNC_STATE: assert property (@(posedge mclk) disable iff (rst)
    async_running |=> async_sched_state) else $error("async state"); // [R02]
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst)
    reg_rdata[31:16] == 16'h0000 && reg_rdata[11:6] == 6'h00)
    else $error("reserved bits nonzero"); // [R20]
  COV_HALT: cover property (@(posedge mclk) $rose(halted_flag));
  COV_ADV: cover property (@(posedge mclk) $rose(events_reg[5]));
  COV_CLR: cover property (@(posedge mclk) reg_wr && sel && |events_reg);
endmodule : host_status_register
`default_nettype wire

// [src/wrap_detect.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hsts_cfg.svh"
// frame list wrap detector: watches the index bit matching the list size
module wrap_detect
  import hsts_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // frame index from the counter
  input wire logic [13:0] frame_index,
  input wire logic [1:0] frame_list_size,
  // one-cycle wrap pulse
  output logic wrap_pulse
);
  logic watched;
  logic watched_reg;
  logic primed_reg;

  // 1024 -> bit 13, 512 -> bit 12, 256 -> bit 11 [R10] [R19]
  always_comb
  begin
    case (frame_list_size)
      2'h0: watched = frame_index[13];
      2'h1: watched = frame_index[12];
      2'h2: watched = frame_index[11];
      default: watched = frame_index[13];
    endcase
  end

  // primed avoids a false wrap from the first sample after reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      watched_reg <= 1'b0;
      primed_reg <= 1'b0;
      wrap_pulse <= 1'b0;
    end
    else
    begin
      watched_reg <= watched;
      primed_reg <= 1'b1;
      wrap_pulse <= primed_reg && (watched != watched_reg); // [R10]
    end
  end
endmodule : wrap_detect
`default_nettype wire

// [verif/host_sw.sv]
`timescale 1ns/100ps
`default_nettype none
// host software model: one strobe per access, launched just after an edge
module host_sw
(
  // clock
  input wire logic mclk,
  // register access
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  // reserved bits go out as zero unless raw asks the model to misbehave
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input bit raw);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= raw ? d : d & 32'h0000_003f;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data must not look valid
  endtask : wr
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_sw
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb
  import hsts_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, run_stop_bit = 1'b0, pipeline_idle = 1'b1;
  logic async_running = 1'b0, periodic_running = 1'b0, async_empty = 1'b0;
  logic [5:0] irq_enable = '0, fl = '0;
  logic [13:0] frame_index = '0;
  logic [1:0] frame_list_size = '0;
  logic [25:0] st = '0;
  logic [31:0] reg_rdata, got, reg_wdata;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, run_stop_clear, irq;
  logic async_sched_state, periodic_sched_state, halted_flag;
  int n_mismatch = 0, num_checks = 0, k, rsc_cnt = 0;
  // events, port change, handoff, force resume, port change any
  logic [25:0] stim [15] = '{26'h3, 26'h2, 26'h80, 26'h100, 26'h200,
    26'hc, 26'h4, 26'h20, 26'h10, 26'h18, 26'h400, 26'h8800, 26'h100000,
    26'h2000040, 26'h40};
  logic [5:0] res [15] = '{6'h20, 6'h0, 6'h10, 6'h10, 6'h10, 6'h1, 6'h0,
    6'h1, 6'h2, 6'h3, 6'h4, 6'h0, 6'h4, 6'h4, 6'h0};

  always #25 mclk = ~mclk;
  // counts stop pulses so a stretched pulse shows up as well
  always @(posedge mclk) if (run_stop_clear) rsc_cnt <= rsc_cnt + 1;

  host_sw u_sw (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  host_status_register #(.NUM_PORTS(4)) u_dut (.mclk, .rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .run_stop_bit, .irq_enable,
    .frame_index, .frame_list_size, .async_running, .periodic_running,
    .async_empty, .pipeline_idle, .async_advanced(st[1]),
    .doorbell_set(st[0]), .td_retired(st[2]), .td_ioc(st[3]),
    .td_error(st[4]), .short_packet(st[5]), .d3_to_d0(st[6]),
    .pci_parity_err(st[7]), .master_abort(st[8]), .target_abort(st[9]),
    .port_change_rise(st[13:10]), .port_handoff(st[17:14]),
    .force_resume_rise(st[21:18]), .port_change_any(st[25:22]),
    .run_stop_clear, .irq, .async_sched_state, .periodic_sched_state,
    .halted_flag);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // index bit whose toggle marks a wrap for each list size
  function automatic int wrap_bit(input int sz);
    return (sz == 2) ? 11 : (sz == 1) ? 12 : 13;
  endfunction : wrap_bit

  // read the word back; halted stays set while run/stop is low
  task automatic look(input logic [5:0] f);
    fl = f;
    u_sw.rd(8'h24, got);
    chk(got, {16'h0, async_running, periodic_running, async_empty,
      ~run_stop_bit, 6'h0, fl});
    chk({31'h0, irq}, {31'h0, |(fl & irq_enable)});
    chk({30'h0, async_sched_state, periodic_sched_state},
      {30'h0, async_running, periodic_running});
  endtask : look

  // doorbell goes out one cycle ahead of the advance it arms
  task automatic fire(input logic [25:0] s);
    if (s[0])
    begin
      @(posedge mclk);
      st <= 26'h1;
    end
    @(posedge mclk);
    st <= s & ~26'h1;
    @(posedge mclk);
    st <= '0;
  endtask : fire

  task automatic step(input int i, input bit rnd);
    logic [31:0] m;
    int c;
    m = rnd ? $urandom : 32'h3f;
    c = rsc_cnt;
    @(posedge mclk);
    irq_enable <= 6'($urandom);
    {async_running, periodic_running, async_empty} <= 3'($urandom);
    fire(stim[i]);
    look(fl | res[i]);
    chk(32'(rsc_cnt - c), 32'(res[i][4]));
    u_sw.wr(8'h24, m, 1'b0);
    look(fl & ~m[5:0]);
  endtask : step

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    k = $urandom(32'h6f03);
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    look(6'h0);
    u_sw.rd(8'h28, got);
    chk(got, 32'h0);
    for (int i = 0; i < 15; i++) step(i, 1'b0);
    repeat (30) step($urandom_range(14, 0), 1'b1);
    // read-only and reserved positions must ignore ones
    fire(26'h20);
    u_sw.wr(8'h24, 32'hffff_ffc0, 1'b1);
    look(fl | 6'h1);
    // a new completion in the cycle of its clear must survive
    fork
      fire(26'h20);
      u_sw.wr(8'h24, 32'h1, 1'b0);
    join
    look(fl | 6'h1);
    // the wrap pulse lands one edge after the index moves
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      frame_list_size <= 2'(i);
      frame_index <= 14'h1 << (wrap_bit(i) - 1);
      look(fl);
      @(posedge mclk);
      frame_index <= 14'h1 << wrap_bit(i);
      @(posedge mclk);
      look(fl | 6'h8);
      u_sw.wr(8'h24, 32'h8, 1'b0);
      look(fl & ~6'h8);
      @(posedge mclk);
      frame_index <= '0;
      repeat (2) @(posedge mclk);
      look(fl | 6'h8);
      u_sw.wr(8'h24, 32'h8, 1'b0);
      look(fl & ~6'h8);
    end
    // halt must wait for the pipeline to go idle
    @(posedge mclk);
    run_stop_bit <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({31'h0, halted_flag}, 32'h0);
    @(posedge mclk);
    run_stop_bit <= 1'b0;
    pipeline_idle <= 1'b0;
    repeat (10) @(negedge mclk);
    chk({31'h0, halted_flag}, 32'h0);
    pipeline_idle <= 1'b1;
    for (int i = 0; i < 12 && halted_flag !== 1'b1; i++)
      @(negedge mclk);
    chk({31'h0, halted_flag}, 32'h1);
    stop_test();
  end
endmodule : tb
`default_nettype wire
